// ===== design/ssc_regs.svh
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH
// Word offsets inside the control block (four words)
`define SSC_CTL_WORDS       3'h4
`define SSC_CTL_SEL_OFS     2'h0
// Word offsets inside the notification block (three words)
`define SSC_NTF_WORDS       2'h3
`define SSC_NTF_SCREEN_OFS  2'h0
`define SSC_NTF_STATUS_OFS  2'h2
// Strobe bit position in the status word
`define SSC_STROBE_BIT      4'hC
// Reset value; select value that never switches
`define SSC_SCREEN_RST      16'h0000
`define SSC_CLEAR_VALUE     16'h0000
`endif

// ===== design/ssc_pkg.sv
package ssc_pkg;
  typedef logic [15:0] ssc_word_t;   // One controller word
  typedef logic [5:0]  ssc_screen_t; // Screen attribute table index
  typedef enum logic [1:0] {
    SSC_IDLE,
    SSC_WRITE_SCREEN,
    SSC_WRITE_STATUS,
    SSC_WAIT_ACK
  } ssc_state_e;
endpackage : ssc_pkg

// ===== design/ssc_bcd_check.sv
// Checks that a word holds four valid BCD digits
module ssc_bcd_check (
  input  wire logic [15:0] word_in,  // Word to check
  output logic             bcd_ok    // High when all digits 0..9
);
  wire logic [3:0] digit_ok; // Per-digit result, one driver per bit

  // One comparator per digit
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dig
      assign digit_ok[g] = (word_in[g*4 +: 4] <= 4'h9);
    end
  endgenerate

  assign bcd_ok = &digit_ok;
endmodule : ssc_bcd_check

// ===== design/ssc_core.sv
// Summary of operation
// - Read four control words; first selects screen
// - Write three notify words; screen, status
// - Screen numbers are four BCD digits
// - Select word switches only when it changes; touch needs no change
// - Controller switch updates displayed screen word
// - Change writes screen word, sets strobe
// - Strobe clears after notification delivered
// - Touch switch notifies like controller switch
// - Group member shows parent group; others show themselves
// - Group shown reports parent screen number
`include "ssc_regs.svh"
module ssc_core (
  input  wire logic        clk_sys,       // System clock, 125 MHz
  input  wire logic        rst_n,         // Sync reset, active low
  input  wire logic        ctl_valid,     // Control word read returned
  input  wire logic [1:0]  ctl_index,     // Index of returned word
  input  wire logic [15:0] ctl_data,      // Returned control word
  input  wire logic        touch_valid,   // Touch key screen request
  input  wire logic [15:0] touch_screen,  // Screen number of touch key
  input  wire logic        parent_valid,  // Selected screen is in a group
  input  wire logic [15:0] parent_screen, // Parent of selected screen
  input  wire logic        ntf_ready,     // Link accepts notify write
  output logic             ntf_valid,     // Notify write request
  output logic [1:0]       ntf_index,     // Notify word index
  output logic [15:0]      ntf_data,      // Notify word data
  output logic [15:0]      shown_screen,  // Screen now displayed
  output logic             shown_group,   // Shown as group from parent
  output logic             strobe_flag    // Screen change strobe
);
  ssc_pkg::ssc_state_e state_reg, state_next; // Notify sequencer
  ssc_pkg::ssc_word_t  last_sel_reg, last_sel_next; // Last acted select
  ssc_pkg::ssc_word_t  shown_reg, shown_next;  // Displayed screen
  logic                group_reg, group_next;  // Group display flag
  logic                strobe_reg, strobe_next; // Strobe bit
  logic [1:0]          idx_reg, idx_next;      // Notify word index
  ssc_pkg::ssc_word_t  data_reg, data_next;    // Notify word data
  logic                sel_ok;                 // Select word is BCD
  logic                touch_ok;               // Touch number is BCD
  logic                sel_hit;                // Fresh select word read
  logic                sel_chg;                // Select differs from last
  logic                do_switch;              // Screen switch this cycle
  ssc_pkg::ssc_word_t  new_screen;             // Screen being switched to

  // BCD check on both request sources
  ssc_bcd_check u_sel_chk (
    .word_in (ctl_data),
    .bcd_ok  (sel_ok)
  );
  ssc_bcd_check u_touch_chk (
    .word_in (touch_screen),
    .bcd_ok  (touch_ok)
  );

  // Decode a switch request
  always_comb begin
    sel_hit = ctl_valid && (ctl_index == `SSC_CTL_SEL_OFS);
    sel_chg = sel_hit && (ctl_data != last_sel_reg);
    new_screen = `SSC_SCREEN_RST;
    do_switch  = 1'b0;
    if (sel_chg && sel_ok && ctl_data != `SSC_CLEAR_VALUE) begin
      new_screen = ctl_data;
      do_switch  = 1'b1;
    end else if (touch_valid && touch_ok) begin
      new_screen = touch_screen;
      do_switch  = 1'b1;
    end
  end

  // Next state of display and notify sequencer
  always_comb begin
    state_next    = state_reg;
    last_sel_next = last_sel_reg;
    shown_next    = shown_reg;
    group_next    = group_reg;
    strobe_next   = strobe_reg;
    idx_next      = idx_reg;
    data_next     = data_reg;
    // Record fresh select values only when idle, so a change that
    // lands mid-notify is still seen on a later read
    if (sel_chg && state_reg == ssc_pkg::SSC_IDLE) begin
      last_sel_next = ctl_data;
    end
    case (state_reg)
      ssc_pkg::SSC_IDLE: begin
        if (do_switch) begin
          // Group member reports its parent
          if (parent_valid) begin
            shown_next = parent_screen;
            group_next = 1'b1;
          end else begin
            shown_next = new_screen;
            group_next = 1'b0;
          end
          strobe_next = 1'b1;
          idx_next    = `SSC_NTF_SCREEN_OFS;
          data_next   = parent_valid ? parent_screen : new_screen;
          state_next  = ssc_pkg::SSC_WRITE_SCREEN;
        end
      end
      ssc_pkg::SSC_WRITE_SCREEN: begin
        // Screen word first, then status word
        if (ntf_ready) begin
          idx_next   = `SSC_NTF_STATUS_OFS;
          data_next  = 16'h0000;
          data_next[`SSC_STROBE_BIT] = 1'b1;
          state_next = ssc_pkg::SSC_WRITE_STATUS;
        end
      end
      ssc_pkg::SSC_WRITE_STATUS: begin
        // Strobe delivered: write it back to zero
        if (ntf_ready) begin
          data_next   = 16'h0000;
          strobe_next = 1'b0;
          state_next  = ssc_pkg::SSC_WAIT_ACK;
        end
      end
      ssc_pkg::SSC_WAIT_ACK: begin
        // Clearing write accepted
        if (ntf_ready) begin
          state_next = ssc_pkg::SSC_IDLE;
        end
      end
      default: begin
        state_next = ssc_pkg::SSC_IDLE;
      end
    endcase
  end

  // Register all state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg    <= ssc_pkg::SSC_IDLE;
      last_sel_reg <= `SSC_SCREEN_RST;
      shown_reg    <= `SSC_SCREEN_RST;
      group_reg    <= 1'b0;
      strobe_reg   <= 1'b0;
      idx_reg      <= 2'h0;
      data_reg     <= 16'h0000;
    end else begin
      state_reg    <= state_next;
      last_sel_reg <= last_sel_next;
      shown_reg    <= shown_next;
      group_reg    <= group_next;
      strobe_reg   <= strobe_next;
      idx_reg      <= idx_next;
      data_reg     <= data_next;
    end
  end

  // Outputs
  assign ntf_valid    = (state_reg != ssc_pkg::SSC_IDLE);
  assign ntf_index    = idx_reg;
  assign ntf_data     = data_reg;
  assign shown_screen = shown_reg;
  assign shown_group  = group_reg;
  assign strobe_flag  = strobe_reg;

  // Assertions
  a_switch_sets_strobe: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (state_reg == ssc_pkg::SSC_IDLE && do_switch) |=> strobe_flag)
    else $error("strobe not set on switch");
  a_same_no_switch: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (state_reg == ssc_pkg::SSC_IDLE && sel_hit && !sel_chg && !touch_valid)
      |=> !strobe_flag)
    else $error("switch without select change");
  a_screen_word_first: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $rose(ntf_valid) |-> (ntf_index == 2'h0 && ntf_data == shown_screen))
    else $error("screen word not first");
  a_strobe_word_set: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (state_reg == ssc_pkg::SSC_WRITE_SCREEN && ntf_ready)
      |=> (ntf_index == 2'h2 && ntf_data[12]))
    else $error("status word lacks strobe");
  a_strobe_clears: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (state_reg == ssc_pkg::SSC_WRITE_STATUS && ntf_ready)
      |=> (!strobe_flag && ntf_data == 16'h0000))
    else $error("strobe not cleared");
  a_parent_report: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (state_reg == ssc_pkg::SSC_IDLE && do_switch && parent_valid)
      |=> (shown_screen == $past(parent_screen) && shown_group))
    else $error("parent not reported");
  a_select_shown: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (state_reg == ssc_pkg::SSC_IDLE && sel_chg && sel_ok
      && ctl_data != 16'h0000 && !parent_valid)
      |=> shown_screen == $past(ctl_data))
    else $error("select not shown");
  a_touch_shown: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (state_reg == ssc_pkg::SSC_IDLE && touch_valid && touch_ok
      && !sel_chg && !parent_valid)
      |=> (shown_screen == $past(touch_screen) && strobe_flag))
    else $error("touch switch not reported");
  a_zero_no_switch: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (state_reg == ssc_pkg::SSC_IDLE && sel_hit && ctl_data == 16'h0000
      && !touch_valid) |=> !strobe_flag)
    else $error("zero select switched");
  // A select read while busy must not count as acted on
  a_busy_keeps_last: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (state_reg != ssc_pkg::SSC_IDLE) |=> $stable(last_sel_reg))
    else $error("select recorded while busy");

  c_select_switch: cover property (@(posedge clk_sys)
    disable iff (!rst_n) sel_chg && do_switch);
  c_touch_switch: cover property (@(posedge clk_sys)
    disable iff (!rst_n) touch_valid && !sel_chg && do_switch);
  c_group_switch: cover property (@(posedge clk_sys)
    disable iff (!rst_n) do_switch && parent_valid);
  c_full_notify: cover property (@(posedge clk_sys)
    disable iff (!rst_n) state_reg == ssc_pkg::SSC_WAIT_ACK && ntf_ready);
endmodule : ssc_core

// ===== test/ssc_link_model.sv
// Controller side of the link: takes notify writes, may stall
module ssc_link_model (
  input  wire logic        clk_sys,   // System clock
  input  wire logic        rst_n,     // Sync reset, active low
  input  wire logic        slow,      // Stall at random when high
  input  wire logic [31:0] rnd,       // Random source
  input  wire logic        ntf_valid, // Notify write request
  input  wire logic [1:0]  ntf_index, // Notify word index
  input  wire logic [15:0] ntf_data,  // Notify word data
  output logic             ntf_ready, // Write taken
  output logic [15:0]      scr_word,  // Stored shown screen word
  output logic [15:0]      sts_word,  // Stored status word
  output logic [15:0]      strobes    // Strobes delivered
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ntf_ready = 1'b1;
  // Ready moves off the sampling edge
  always @(negedge clk_sys) ntf_ready <= !(slow && rnd[3]);
  // Store words at the accepting edge
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      scr_word <= 16'h0000;
      sts_word <= 16'h0000;
      strobes  <= 16'h0000;
    end else if (ntf_valid && ntf_ready) begin
      if (ntf_index == 2'h0) scr_word <= ntf_data;
      if (ntf_index == 2'h2) sts_word <= ntf_data;
      // Count each status write that carries the strobe
      if (ntf_index == 2'h2 && ntf_data[12]) strobes <= strobes + 16'h0001;
    end
  end
endmodule : ssc_link_model

// ===== test/screen_switch_control_bench.sv
// Random and corner screen switches against the link model
module screen_switch_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic        ctl_valid = 1'b0, touch_valid = 1'b0, parent_valid = 1'b0;
  logic [1:0]  ctl_index = 2'h0;
  logic [15:0] ctl_data = 16'h0000, touch_screen = 16'h0000;
  logic [15:0] parent_screen = 16'h0000, last = 16'h0000, v;
  logic [31:0] rnd = 32'hABB1;
  logic [31:0] lrnd = 32'hABB1; // Per-cycle random for link stalls
  logic        ntf_valid, ntf_ready, shown_group, strobe_flag, t;
  logic [1:0]  ntf_index;
  logic [15:0] ntf_data, shown_screen, scr_word, sts_word, strobes;
  int          fails = 0, total_checks = 0;
  always #4 clk_sys = ~clk_sys;
  ssc_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ctl_valid(ctl_valid),
    .ctl_index(ctl_index), .ctl_data(ctl_data), .touch_valid(touch_valid),
    .touch_screen(touch_screen), .parent_valid(parent_valid),
    .parent_screen(parent_screen), .ntf_ready(ntf_ready),
    .ntf_valid(ntf_valid), .ntf_index(ntf_index), .ntf_data(ntf_data),
    .shown_screen(shown_screen), .shown_group(shown_group),
    .strobe_flag(strobe_flag));
  ssc_link_model i_link (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow),
    .rnd(lrnd), .ntf_valid(ntf_valid), .ntf_index(ntf_index),
    .ntf_data(ntf_data), .ntf_ready(ntf_ready), .scr_word(scr_word),
    .sts_word(sts_word), .strobes(strobes));
  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction : xs
  // Link stall pattern moves every cycle, not once per step
  always @(negedge clk_sys) lrnd <= xs(lrnd);
  // Four valid decimal digits from random bits
  function automatic logic [15:0] bcd4(input logic [31:0] s);
    logic [15:0] r;
    for (int i = 0; i < 4; i++) r[i*4+:4] = 4'(s[i*5+:5] % 5'hA);
    return r;
  endfunction : bcd4
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // One request, then a bounded wait until notify is done
  task automatic step(input logic [1:0] i, input logic [15:0] d,
                      input logic tch, input logic sw);
    logic [15:0] n0, ex;
    int n;
    n0 = strobes;
    n = 0;
    ex = parent_valid ? parent_screen : d;
    @(negedge clk_sys);
    ctl_valid = !tch;
    touch_valid = tch;
    ctl_index = i;
    ctl_data = d;
    touch_screen = d;
    @(negedge clk_sys);
    ctl_valid = 1'b0;
    touch_valid = 1'b0;
    if (!tch && i == 2'h0) last = d;
    repeat (3) @(negedge clk_sys);
    while (ntf_valid !== 1'b0 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 200) begin
      fails++;
      give_verdict();
    end
    check(strobes, n0 + {15'h0, sw});
    if (sw) begin
      check(scr_word, ex);
      check(shown_screen, ex);
      check({15'h0, shown_group}, {15'h0, parent_valid});
      check(sts_word, 16'h0000);
      check({15'h0, strobe_flag}, 16'h0000);
    end
  endtask : step
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    check(shown_screen, 16'h0000);
    step(2'h0, 16'h0002, 1'b0, 1'b1);
    step(2'h0, 16'h0002, 1'b0, 1'b0);
    step(2'h0, 16'h0000, 1'b0, 1'b0);
    step(2'h0, 16'h0002, 1'b0, 1'b1);
    step(2'h1, 16'h0007, 1'b0, 1'b0);
    step(2'h0, 16'h00A1, 1'b0, 1'b0);
    step(2'h0, 16'h9999, 1'b0, 1'b1);
    step(2'h0, 16'h0003, 1'b1, 1'b1);
    // Controller copies the shown word into its select word
    step(2'h0, scr_word, 1'b0, 1'b1);
    // Select change that arrives during a notify
    @(negedge clk_sys);
    touch_valid = 1'b1;
    touch_screen = 16'h0004;
    @(negedge clk_sys);
    touch_valid = 1'b0;
    ctl_valid = 1'b1;
    ctl_index = 2'h0;
    ctl_data = 16'h0006;
    @(negedge clk_sys);
    ctl_valid = 1'b0;
    repeat (6) @(negedge clk_sys);
    step(2'h0, 16'h0006, 1'b0, 1'b1);
    parent_valid = 1'b1;
    parent_screen = 16'h0010;
    step(2'h0, 16'h0005, 1'b0, 1'b1);
    slow = 1'b1;
    // Random mix with repeats, touches and groups
    repeat (80) begin
      rnd = xs(rnd);
      v = (rnd[31:30] == 2'h0) ? last : bcd4(rnd);
      t = rnd[29];
      parent_valid = rnd[28];
      parent_screen = bcd4(rnd >> 7);
      step(2'h0, v, t, t || (v !== last && v !== 16'h0000));
    end
    give_verdict();
  end
endmodule : screen_switch_control_bench
